// [design/cgu_defs.svh]
/*
 * Register offsets, field positions, reset values and counts for the
 * clock generation unit base clock block.
 * Assumes a byte-addressed Avalon-MM slave with 32-bit data words.
 */
`ifndef CGU_DEFS_SVH
`define CGU_DEFS_SVH

`define CGU_OFS_CTRL 5'h00
`define CGU_OFS_MULR 5'h04
`define CGU_OFS_STAT 5'h08
`define CGU_OFS_IRQS 5'h0c
`define CGU_OFS_IRQM 5'h10

`define CGU_CTRL_IE 7
`define CGU_CTRL_FLAG 6
`define CGU_CTRL_PWR 5
`define CGU_CTRL_BCS 4
`define CGU_CTRL_UNUSED 4'hf

`define CGU_IRQ_LOCK 0
`define CGU_IRQ_SWDONE 1

`define CGU_MUL_RESET 4'h6
`define CGU_RANGE_RESET 4'h6
`define CGU_MUL_ZERO_AS 4'h1
`define CGU_SWITCH_EDGES 2'h3

`endif

// [design/cgu_pkg.sv]
/*
 * Types shared by the clock generation unit block.
 * Assumes cgu_defs.svh supplies the numeric constants.
 */
package cgu_pkg;

    typedef enum logic [1:0] {
        CGU_SW_IDLE = 2'b00,
        CGU_SW_OLD = 2'b01,
        CGU_SW_NEW = 2'b10
    } cgu_sw_state_e;

endpackage : cgu_pkg

// [design/cgu_base_clock.sv]
/*
 * Digital control of the clock generation unit: multiplier and range
 * register, power and base clock select interlocks, glitch-free source
 * switch with divide by two, lock change flag and interrupt.
 * Assumes crystal_clock, vco_clock and lock_in are synchronous to clock
 * and slower than half its rate; stop_req is a one-cycle pulse.
 */
`timescale 1ns/1ns
`include "cgu_defs.svh"

// Behaviour
// (R01) Multiplier zero acts as multiplier one
// (R02) Range zero disables loop, blocks VCO select
// (R03) Switch waits three edges each, output held
// (R04) Switched clock divided by two for base
// (R05) Bus rate is quarter of source rate
// (R06) Select bit picks crystal or VCO clock
// (R07) No VCO select while power is off
// (R08) No power off while VCO selected
// (R09) Power and select change in separate writes
// (R10) Range zero forces crystal as source
// (R11) Software puts multiplier high, range low
// (R12) Integration module drives oscillator enable
// (R13) Base clock has even duty, twice bus
// (R14) Lock detector sources the interrupt
// (R15) Lock toggle sets flag; control read clears
// (R16) Multiplier and range locked while powered
// (R17) Reset loads multiplier with six
// (R18) Reset and stop clear select bit
// (R19) Gate old clock off before new on
module cgu_base_clock (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic crystal_clock,
    input wire logic vco_clock,
    input wire logic osc_enable_in,
    input wire logic lock_in,
    input wire logic stop_req,
    output logic base_clock_out,
    output logic bus_clock_en,
    output logic vco_enable,
    output logic [3:0] feedback_divisor,
    output logic [3:0] range_select_out,
    output logic clock_switching,
    output logic lock_change_irq
);

    logic wait_reg;
    logic [31:0] rdata_reg;
    logic irq_en_reg;
    logic flag_reg;
    logic pwr_reg;
    logic bcs_reg;
    logic [3:0] mul_reg;
    logic [3:0] range_reg;
    logic [1:0] irq_st_reg;
    logic [1:0] irq_mask_reg;
    logic lock_q;
    logic xclk_q;
    logic vclk_q;
    logic cur_src_reg;
    logic [1:0] cnt_reg;
    cgu_pkg::cgu_sw_state_e sw_reg;
    logic base_reg;
    logic bus_en_reg;
    logic vco_en_reg;
    logic [3:0] div_reg;
    logic [3:0] range_out_reg;
    logic irq_reg;
    logic done_pulse;
    logic bus_ph_reg;
    logic busy_reg;

    logic take;
    logic wr_take;
    logic [7:0] wd;
    logic range_zero;
    logic lock_toggle;
    logic x_edge;
    logic v_edge;
    logic old_edge;
    logic new_edge;
    logic pwr_next;
    logic [7:0] ctrl_view;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;

    assign take = (read | write) & ~wait_reg;
    assign wr_take = take & write & byteenable[0];
    assign wd = writedata[7:0];
    assign range_zero = (range_reg == 4'h0);
    assign lock_toggle = lock_in ^ lock_q;
    assign x_edge = crystal_clock & ~xclk_q;
    assign v_edge = vco_clock & vco_en_reg & ~vclk_q;
    assign old_edge = cur_src_reg ? v_edge : x_edge;
    assign new_edge = cur_src_reg ? x_edge : v_edge;
    assign pwr_next = bcs_reg | cur_src_reg | wd[`CGU_CTRL_PWR]; // [R08]
    assign ctrl_view = {irq_en_reg, flag_reg, pwr_reg, bcs_reg,
        `CGU_CTRL_UNUSED};
    assign irq_set[`CGU_IRQ_LOCK] = lock_toggle;
    assign irq_set[`CGU_IRQ_SWDONE] = done_pulse;
    assign irq_clr = (wr_take && address == `CGU_OFS_IRQS) ? wd[1:0] : 2'h0;

    // Bus handshake: one wait cycle, answer, then take at next edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else if ((read | write) & wait_reg) begin
            wait_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            unique case (address)
                `CGU_OFS_CTRL: rdata_reg[7:0] <= ctrl_view;
                `CGU_OFS_MULR: rdata_reg[7:0] <= {mul_reg, range_reg};
                `CGU_OFS_STAT: rdata_reg[2:0] <= {lock_q, clock_switching,
                    cur_src_reg};
                `CGU_OFS_IRQS: rdata_reg[1:0] <= irq_st_reg;
                `CGU_OFS_IRQM: rdata_reg[1:0] <= irq_mask_reg;
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            wait_reg <= 1'b1;
        end
    end

    // Power switch, select bit and interrupt enable
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_en_reg <= 1'b0;
            pwr_reg <= 1'b1;
            bcs_reg <= 1'b0; // [R18]
        end else begin
            if (wr_take && address == `CGU_OFS_CTRL) begin
                irq_en_reg <= wd[`CGU_CTRL_IE];
                if (pwr_next != pwr_reg) begin
                    pwr_reg <= pwr_next; // [R09]
                end else begin
                    bcs_reg <= wd[`CGU_CTRL_BCS] & pwr_reg; // [R06] [R07]
                end
            end
            if (stop_req || range_zero) begin
                bcs_reg <= 1'b0; // [R02] [R10] [R18]
            end
        end
    end

    // Multiplier and range fields
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mul_reg <= `CGU_MUL_RESET; // [R17]
            range_reg <= `CGU_RANGE_RESET;
        end else if (wr_take && address == `CGU_OFS_MULR && !pwr_reg) begin
            mul_reg <= wd[7:4]; // [R11] [R16]
            range_reg <= wd[3:0];
        end
    end

    // Lock change flag: set beats the read clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
            flag_reg <= 1'b0;
        end else begin
            lock_q <= lock_in;
            if (lock_toggle) begin
                flag_reg <= 1'b1; // [R15]
            end else if (take && read && address == `CGU_OFS_CTRL) begin
                flag_reg <= 1'b0; // [R15]
            end
        end
    end

    // Sticky interrupt status, write one to clear, mask and output
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_st_reg <= 2'h0;
            irq_mask_reg <= 2'h0;
            irq_reg <= 1'b0;
        end else begin
            irq_st_reg <= irq_set | (irq_st_reg & ~irq_clr);
            if (wr_take && address == `CGU_OFS_IRQM) begin
                irq_mask_reg <= wd[1:0];
            end
            irq_reg <= (flag_reg & irq_en_reg) |
                (|(irq_st_reg & irq_mask_reg)); // [R14]
        end
    end

    // Source edge detection
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            xclk_q <= 1'b0;
            vclk_q <= 1'b0;
        end else begin
            xclk_q <= crystal_clock;
            vclk_q <= vco_clock & vco_en_reg;
        end
    end

    // Transition control: drain old source, then arm new source
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sw_reg <= cgu_pkg::CGU_SW_IDLE;
            cnt_reg <= 2'h0;
            cur_src_reg <= 1'b0;
            done_pulse <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            unique case (sw_reg)
                cgu_pkg::CGU_SW_IDLE: begin
                    cnt_reg <= 2'h0;
                    if (bcs_reg != cur_src_reg) begin
                        sw_reg <= cgu_pkg::CGU_SW_OLD; // [R19]
                        busy_reg <= 1'b1;
                    end
                end
                cgu_pkg::CGU_SW_OLD: begin
                    if (old_edge) begin
                        if (cnt_reg == `CGU_SWITCH_EDGES - 2'h1) begin
                            cnt_reg <= 2'h0;
                            sw_reg <= cgu_pkg::CGU_SW_NEW; // [R03]
                        end else begin
                            cnt_reg <= cnt_reg + 2'h1;
                        end
                    end
                end
                cgu_pkg::CGU_SW_NEW: begin
                    if (new_edge) begin
                        if (cnt_reg == `CGU_SWITCH_EDGES - 2'h1) begin
                            cnt_reg <= 2'h0;
                            cur_src_reg <= ~cur_src_reg; // [R03] [R19]
                            sw_reg <= cgu_pkg::CGU_SW_IDLE;
                            done_pulse <= 1'b1;
                            busy_reg <= 1'b0;
                        end else begin
                            cnt_reg <= cnt_reg + 2'h1;
                        end
                    end
                end
                default: sw_reg <= cgu_pkg::CGU_SW_IDLE;
            endcase
        end
    end

    // Divide by two of the active source; bus enable every second fall
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            base_reg <= 1'b0;
            bus_ph_reg <= 1'b0;
            bus_en_reg <= 1'b0;
        end else if (sw_reg == cgu_pkg::CGU_SW_IDLE && old_edge) begin
            base_reg <= ~base_reg; // [R04] [R13]
            bus_ph_reg <= bus_ph_reg ^ base_reg;
            bus_en_reg <= base_reg & bus_ph_reg; // [R05]
        end else begin
            bus_en_reg <= 1'b0;
        end
    end

    // Loop enable and effective divider values
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            vco_en_reg <= 1'b0;
            div_reg <= `CGU_MUL_RESET;
            range_out_reg <= `CGU_RANGE_RESET;
        end else begin
            vco_en_reg <= pwr_reg & osc_enable_in & ~range_zero; // [R02] [R12]
            div_reg <= (mul_reg == 4'h0) ? `CGU_MUL_ZERO_AS : mul_reg; // [R01]
            range_out_reg <= range_reg;
        end
    end

    assign readdata = rdata_reg;
    assign waitrequest = wait_reg;
    assign base_clock_out = base_reg;
    assign bus_clock_en = bus_en_reg;
    assign vco_enable = vco_en_reg;
    assign feedback_divisor = div_reg;
    assign range_select_out = range_out_reg;
    assign clock_switching = busy_reg;
    assign lock_change_irq = irq_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_switch_start;
        sw_reg == cgu_pkg::CGU_SW_IDLE && bcs_reg != cur_src_reg;
    endsequence
    property p_mul_zero;
        mul_reg == 4'h0 |=> div_reg == `CGU_MUL_ZERO_AS;
    endproperty
    a_mul_zero: assert property (p_mul_zero) // [R01]
        else $error("zero multiplier not read as one");
    property p_range_zero;
        range_zero |=> !bcs_reg && !vco_en_reg;
    endproperty
    a_range_zero: assert property (p_range_zero) // [R02]
        else $error("zero range left loop or select active");
    property p_hold;
        clock_switching |=> $stable(base_reg);
    endproperty
    a_hold: assert property (p_hold) // [R03]
        else $error("base clock moved during transition");
    property p_div2;
        $changed(base_reg) |-> $past(old_edge) && !$past(clock_switching);
    endproperty
    a_div2: assert property (p_div2) // [R04]
        else $error("base clock toggled without source edge");
    property p_bus;
        bus_en_reg == ($fell(base_reg) && !bus_ph_reg);
    endproperty
    a_bus: assert property (p_bus) // [R05]
        else $error("bus enable not on every second base fall");
    property p_no_vco_off;
        !pwr_reg && !bcs_reg |=> !bcs_reg;
    endproperty
    a_no_vco_off: assert property (p_no_vco_off) // [R07]
        else $error("select set while power off");
    property p_keep_pwr;
        bcs_reg || cur_src_reg |=> pwr_reg;
    endproperty
    a_keep_pwr: assert property (p_keep_pwr) // [R08]
        else $error("power cleared with VCO selected");
    property p_separate;
        $changed(pwr_reg) |-> !$rose(bcs_reg);
    endproperty
    a_separate: assert property (p_separate) // [R09]
        else $error("power and select changed together");
    property p_flag;
        lock_toggle |=> flag_reg;
    endproperty
    a_flag: assert property (p_flag) // [R15]
        else $error("lock toggle did not set flag");
    property p_irq;
        flag_reg && irq_en_reg |=> irq_reg;
    endproperty
    a_irq: assert property (p_irq) // [R14]
        else $error("enabled flag raised no interrupt");
    property p_lock_fields;
        pwr_reg |=> $stable(mul_reg) && $stable(range_reg);
    endproperty
    a_lock_fields: assert property (p_lock_fields) // [R16]
        else $error("fields written while powered");
    property p_stop;
        stop_req |=> !bcs_reg;
    endproperty
    a_stop: assert property (p_stop) // [R18]
        else $error("stop did not clear select");
    property p_order;
        s_switch_start |=> sw_reg == cgu_pkg::CGU_SW_OLD
            && $stable(cur_src_reg);
    endproperty
    a_order: assert property (p_order) // [R19]
        else $error("switch skipped old source drain");

endmodule : cgu_base_clock

// [test/cgu_sim_model.sv]
/*
 * Integration module model: drives the oscillator enable and makes the
 * crystal and VCO source clocks, both slower than half the system clock.
 * Assumes one system clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns
module cgu_sim_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic vco_enable,
    output logic osc_enable_in,
    output logic crystal_clock,
    output logic vco_clock
);
    logic [1:0] xc_reg;
    logic vc_reg;
    // Oscillator enabled once out of reset
    always_ff @(posedge clock) begin
        osc_enable_in <= rst_n;
    end
    // Crystal toggles every third cycle: period of six cycles
    always_ff @(posedge clock) begin
        if (!rst_n || xc_reg == 2'h2) begin
            xc_reg <= 2'h0;
        end else begin
            xc_reg <= xc_reg + 2'h1;
        end
        if (!rst_n) begin
            crystal_clock <= 1'b0;
        end else if (xc_reg == 2'h2) begin
            crystal_clock <= ~crystal_clock;
        end
    end
    // VCO runs only while enabled, period of four cycles
    always_ff @(posedge clock) begin
        if (!rst_n || !vco_enable) begin
            vc_reg <= 1'b0;
            vco_clock <= 1'b0;
        end else begin
            vc_reg <= ~vc_reg;
            if (vc_reg) begin
                vco_clock <= ~vco_clock;
            end
        end
    end
endmodule : cgu_sim_model

// [test/cgu_base_clock_tb.sv]
/*
 * Testbench for the base clock block: register table rows, then source
 * switching, divide ratios, interlocks and interrupts.
 * Assumes the integration module model supplies the source clocks.
 */
`timescale 1ns/1ns
`include "cgu_defs.svh"
module cgu_base_clock_tb;
    logic clock, rst_n, read, write, lock_in, stop_req;
    logic crystal_clock, vco_clock, osc_enable_in, waitrequest;
    logic base_clock_out, bus_clock_en, vco_enable, clock_switching;
    logic lock_change_irq;
    logic [4:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] byteenable, feedback_divisor, range_select_out;
    int fails, num_checks, cyc, hi, lo, frz, k;
    typedef struct {
        logic [4:0] a; logic [7:0] d; logic [3:0] be; logic [7:0] e;
    } cgu_row_s;
    cgu_row_s rows [7] = '{
        '{5'h04, 8'h33, 4'h1, 8'h66},
        '{5'h00, 8'h00, 4'h0, 8'h2f},
        '{5'h00, 8'h00, 4'h1, 8'h0f},
        '{5'h00, 8'h10, 4'h1, 8'h0f},
        '{5'h04, 8'h07, 4'h1, 8'h07},
        '{5'h14, 8'hff, 4'h1, 8'h00},
        '{5'h00, 8'h30, 4'h1, 8'h2f}};
    cgu_base_clock dut (.clock(clock), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .crystal_clock(crystal_clock),
        .vco_clock(vco_clock), .osc_enable_in(osc_enable_in),
        .lock_in(lock_in), .stop_req(stop_req),
        .base_clock_out(base_clock_out), .bus_clock_en(bus_clock_en),
        .vco_enable(vco_enable), .feedback_divisor(feedback_divisor),
        .range_select_out(range_select_out),
        .clock_switching(clock_switching),
        .lock_change_irq(lock_change_irq));
    cgu_sim_model sim (.clock(clock), .rst_n(rst_n),
        .vco_enable(vco_enable), .osc_enable_in(osc_enable_in),
        .crystal_clock(crystal_clock), .vco_clock(vco_clock));
    task automatic summarize();
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic bus(input logic [4:0] a, input logic w,
        input logic [7:0] d, input logic [3:0] be);
        @(posedge clock);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= {24'h0, d};
        byteenable <= be;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic rdc(input string s, input logic [4:0] a,
        input logic [7:0] e);
        bus(a, 1'b0, 8'h00, 4'h1);
        chk(s, {24'h0, e}, rd);
    endtask : rdc
    task automatic meas(output int h, output int l);
        int n = 0;
        h = 0;
        l = 0;
        while (base_clock_out !== 1'b0 && n < 60) begin
            @(posedge clock);
            n++;
        end
        while (base_clock_out !== 1'b1 && n < 60) begin
            @(posedge clock);
            n++;
        end
        while (base_clock_out === 1'b1 && n < 60) begin
            @(posedge clock);
            n++;
            h++;
        end
        while (base_clock_out === 1'b0 && n < 60) begin
            @(posedge clock);
            n++;
            l++;
        end
    endtask : meas
    task automatic wsw(output int f);
        int n = 0;
        logic b;
        f = 0;
        while (clock_switching !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        b = base_clock_out;
        do begin
            @(posedge clock);
            n++;
            if (clock_switching === 1'b1 && base_clock_out !== b) f++;
        end while (clock_switching === 1'b1 && n < 300);
        if (clock_switching !== 1'b0) f++;
    endtask : wsw
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        {rst_n, read, write, lock_in, stop_req} = 5'h0;
        address = 5'h00;
        writedata = 32'h0;
        byteenable = 4'h1;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        chk("divisor", 32'h6, feedback_divisor);
        rdc("ctrl", `CGU_OFS_CTRL, 8'h2f);
        foreach (rows[i]) begin
            bus(rows[i].a, 1'b1, rows[i].d, rows[i].be);
            rdc("row", rows[i].a, rows[i].e);
        end
        chk("mul0", 32'h1, feedback_divisor);
        bus(`CGU_OFS_CTRL, 1'b1, 8'h30, 4'h1);
        wsw(frz);
        chk("frozen", 32'h0, frz);
        rdc("stat", `CGU_OFS_STAT, 8'h01);
        rdc("done", `CGU_OFS_IRQS, 8'h02);
        meas(hi, lo);
        chk("vco_hi", 32'h4, hi);
        chk("vco_lo", 32'h4, lo);
        bus(`CGU_OFS_CTRL, 1'b1, 8'h10, 4'h1);
        rdc("pwroff", `CGU_OFS_CTRL, 8'h3f);
        stop_req <= 1'b1;
        @(posedge clock);
        stop_req <= 1'b0;
        rdc("stop", `CGU_OFS_CTRL, 8'h2f);
        wsw(frz);
        chk("frozen2", 32'h0, frz);
        meas(hi, lo);
        chk("xtal_hi", 32'h6, hi);
        chk("xtal_lo", 32'h6, lo);
        k = 0;
        repeat (48) begin
            @(posedge clock);
            if (bus_clock_en === 1'b1) k++;
        end
        chk("bus_en", 32'h2, k);
        bus(`CGU_OFS_CTRL, 1'b1, 8'h00, 4'h1);
        bus(`CGU_OFS_MULR, 1'b1, 8'h10, 4'h1);
        bus(`CGU_OFS_CTRL, 1'b1, 8'h20, 4'h1);
        bus(`CGU_OFS_CTRL, 1'b1, 8'h30, 4'h1);
        rdc("rng0", `CGU_OFS_CTRL, 8'h2f);
        chk("vco_en", 32'h0, vco_enable);
        chk("range", 32'h0, range_select_out);
        bus(`CGU_OFS_IRQS, 1'b1, 8'h03, 4'h1);
        bus(`CGU_OFS_IRQM, 1'b1, 8'h01, 4'h1);
        lock_in <= 1'b1;
        repeat (4) @(posedge clock);
        chk("irq_on", 32'h1, lock_change_irq);
        bus(`CGU_OFS_IRQS, 1'b1, 8'h01, 4'h1);
        repeat (2) @(posedge clock);
        chk("irq_clr", 32'h0, lock_change_irq);
        bus(`CGU_OFS_IRQM, 1'b1, 8'h00, 4'h1);
        lock_in <= 1'b0;
        repeat (4) @(posedge clock);
        chk("irq_mask", 32'h0, lock_change_irq);
        rdc("flag", `CGU_OFS_CTRL, 8'h6f);
        bus(`CGU_OFS_CTRL, 1'b1, 8'ha0, 4'h1);
        lock_in <= 1'b1;
        repeat (4) @(posedge clock);
        chk("irq_ie", 32'h1, lock_change_irq);
        rdc("flag_ie", `CGU_OFS_CTRL, 8'hef);
        repeat (2) @(posedge clock);
        chk("irq_rd", 32'h0, lock_change_irq);
        summarize();
    end
endmodule : cgu_base_clock_tb
